/* File: adc_input_select.sv */
// Purpose: Control registers and input selection for a four-input sampling converter
// Assumes: Parallel bus pins are asynchronous; conversion events come from core logic
// Notes:   Writes take effect a few clocks after the write strobe falls
`timescale 1ns/100ps
`default_nettype none
`include "adc_sel_map.svh"

// What this block does
// - Bits 3 and 4 of the input configuration choose which input or pair is converted.
// - Bit 5 selects differential, with 00100 giving pair A and 00101 giving pair B.
// - Bits 6 and 7 select the autoscan setup when several inputs repeat in sequence.
// - With bits 7 to 5 clear, channel codes 0 to 3 pick the four single-ended inputs.
// - Code 10001 alternates between the two A inputs single-ended.
// - Code 10010 cycles through A positive, A negative and B positive.
// - Code 10011 cycles through all four single-ended inputs.
// - Code 10101 alternates A positive with the B differential pair.
// - Code 10110 cycles A positive, A negative, then the B pair.
// - Code 11001 alternates the A pair and the B pair.
// - Bits 8 and 9 are the test field, and 00 means normal conversion.
// - Test values 01, 10 and 11 convert the upper, mid and lower reference.
// - The second register is ten bits; trigger, strobe and format are stored, reset and overflow are not.
// - After reset the channel field is 00, bit 5 is 1, bit 6 is 0 and scan is off.
// - Writing 1 to the soft reset bit restores both registers to their reset values.
module adc_input_select (
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic [`BUS_WIDTH-1:0]   bus_data_i,
	input  wire logic                    bus_wr_n_i,
	input  wire logic                    bus_rd_n_i,
	input  wire logic                    conv_done_i,
	input  wire logic                    queue_overflow_i,
	output logic      [`CFG_WIDTH-1:0]   read_data_o,
	output logic                         read_data_oe_o,
	output adc_sel_pkg::src_t            convert_src_o,
	output logic      [1:0]              seq_index_o,
	output logic                         scan_active_o,
	output logic                         vref_external_o,
	output logic                         single_conv_mode_o,
	output logic                         power_down_o,
	output logic      [1:0]              trigger_level_o,
	output logic                         avail_pulse_type_o,
	output logic                         avail_active_high_o,
	output logic                         strobe_rw_style_o,
	output logic                         output_number_format_o,
	output logic                         offset_enable_o,
	output logic                         register_readback_o,
	output logic                         queue_clear_o,
	output logic                         soft_reset_o
);
	import adc_sel_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	// Data and strobes share one synchroniser so they stay aligned
	logic [`BUS_WIDTH+1:0] pins_sync;
	logic [`BUS_WIDTH-1:0] data_s;
	logic                  wr_n_s;
	logic                  rd_n_s;

	// Strobe stages reset high, the idle level of the pins
	pin_sync #(
		.WIDTH       (`BUS_WIDTH + 2),
		.RESET_LEVEL ({2'h3, {`BUS_WIDTH{1'b0}}})
	) u_pin_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    ({bus_rd_n_i, bus_wr_n_i, bus_data_i}),
		.sync_o     (pins_sync)
	);

	// Address rides on the two top data lines
	assign data_s = pins_sync[`BUS_WIDTH-1:0];
	assign wr_n_s = pins_sync[`BUS_WIDTH];
	assign rd_n_s = pins_sync[`BUS_WIDTH+1];

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	// Configuration words, flags and strobe history
	logic [`CFG_WIDTH-1:0] cr0_reg;
	logic [`CFG_WIDTH-1:0] cr0_next;
	logic [`CFG_WIDTH-1:0] cr1_reg;
	logic [`CFG_WIDTH-1:0] cr1_next;
	logic                  overflow_flag_reg;
	logic                  overflow_flag_next;
	logic                  wr_prev_reg;
	logic                  rd_prev_reg;
	logic                  qclr_reg;
	logic                  qclr_next;
	logic                  srst_reg;
	logic                  srst_next;
	logic [`CFG_WIDTH-1:0] rdata_reg;
	logic [`CFG_WIDTH-1:0] rdata_next;
	logic                  oe_reg;
	logic                  wr_pulse;
	logic                  rd_pulse;
	logic                  wr_cr0;
	logic                  wr_cr1;
	logic                  soft_rst;
	logic [1:0]            addr_s;

	// Strobe edges seen on synchronised pins
	assign wr_pulse = wr_prev_reg & ~wr_n_s;
	assign rd_pulse = rd_prev_reg & ~rd_n_s;
	assign addr_s   = data_s[`CFG_ADDR_HI:`CFG_ADDR_LO];
	// Addresses 2 and 3 match neither decode and are dropped
	assign wr_cr0   = wr_pulse && (addr_s == `CFG_ADDR_CR0);
	assign wr_cr1   = wr_pulse && (addr_s == `CFG_ADDR_CR1);
	assign soft_rst = wr_cr1 && data_s[`CR1_SOFT_RST_BIT];

	// Register updates; soft reset beats an ordinary write in the same cycle
	always_comb begin
		// Registers hold by default; pulses last one cycle
		cr0_next   = cr0_reg;
		cr1_next   = cr1_reg;
		qclr_next  = 1'b0;
		srst_next  = soft_rst;
		rdata_next = rdata_reg;
		// Overflow events win over a clearing read
		overflow_flag_next  = queue_overflow_i | (overflow_flag_reg & ~rd_pulse);
		if (soft_rst) begin
			cr0_next  = `CR0_RESET_VALUE;
			cr1_next  = `CR1_RESET_VALUE;
			overflow_flag_next = queue_overflow_i;
		end else if (wr_cr0) begin
			cr0_next = data_s[`CFG_WIDTH-1:0];
		end else if (wr_cr1) begin
			// ten-bit layout; bits 0 and 1 are not stored
			cr1_next  = {data_s[`CFG_WIDTH-1:`CR1_TRIG_LO], 2'h0};
			qclr_next = data_s[`CR1_OVERFLOW_FLAG_BIT];
		end
		// Reads return the queue/interface register with the live overflow flag
		if (rd_pulse) begin
			rdata_next = {cr1_reg[`CFG_WIDTH-1:`CR1_TRIG_LO], overflow_flag_reg, 1'b0};
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cr0_reg     <= `CR0_RESET_VALUE;
			cr1_reg     <= `CR1_RESET_VALUE;
			overflow_flag_reg    <= 1'b0;
			wr_prev_reg <= 1'b1;
			rd_prev_reg <= 1'b1;
			qclr_reg    <= 1'b0;
			srst_reg    <= 1'b0;
			rdata_reg   <= '0;
			oe_reg      <= 1'b0;
		end else begin
			cr0_reg     <= cr0_next;
			cr1_reg     <= cr1_next;
			overflow_flag_reg    <= overflow_flag_next;
			wr_prev_reg <= wr_n_s;
			rd_prev_reg <= rd_n_s;
			qclr_reg    <= qclr_next;
			srst_reg    <= srst_next;
			rdata_reg   <= rdata_next;
			oe_reg      <= ~rd_n_s;
		end
	end

	// ------------------------------------------------------------------
	// Input selection
	// ------------------------------------------------------------------
	// Registered source keeps decode glitches off the front end
	src_t       seq_src;
	logic [1:0] seq_idx;
	logic       seq_scan;
	src_t       src_reg;
	src_t       src_next;
	logic [1:0] idx_reg;
	logic       scan_reg;
	test_t      test_mode;

	// An input register write or a soft reset restarts the scan at its first entry
	// Each finished conversion advances the scan by one entry
	scan_sequencer u_scan (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.sel_code_i (cr0_reg[`CR0_SEL_HI:`CR0_SEL_LO]),
		.restart_i  (wr_cr0 | soft_rst),
		.step_i     (conv_done_i),
		.src_o      (seq_src),
		.index_o    (seq_idx),
		.scan_o     (seq_scan)
	);

	// Test field read as a typed value for the override
	assign test_mode = test_t'(cr0_reg[`CR0_TEST_HI:`CR0_TEST_LO]);

	always_comb begin
		case (test_mode)
			TEST_NORMAL: src_next = seq_src;
			TEST_REF_HI: src_next = SRC_REF_HI;
			TEST_REF_MD: src_next = SRC_REF_MID;
			TEST_REF_LO: src_next = SRC_REF_LO;
			default:     src_next = seq_src;
		endcase
	end

	// Source flops; reset shows the default pair A
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_reg  <= SRC_DIFF_A;
			idx_reg  <= 2'h0;
			scan_reg <= 1'b0;
		end else begin
			src_reg  <= src_next;
			idx_reg  <= seq_idx;
			scan_reg <= seq_scan;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------------
	// Stored-only settings go straight out of their register bits
	assign read_data_o            = rdata_reg;
	assign read_data_oe_o         = oe_reg;
	assign convert_src_o          = src_reg;
	assign seq_index_o            = idx_reg;
	assign scan_active_o          = scan_reg;
	assign vref_external_o        = cr0_reg[`CR0_VREF_BIT];
	assign single_conv_mode_o     = cr0_reg[`CR0_MODE_BIT];
	assign power_down_o           = cr0_reg[`CR0_PD_BIT];
	assign trigger_level_o        = cr1_reg[`CR1_TRIG_HI:`CR1_TRIG_LO];
	assign avail_pulse_type_o     = cr1_reg[`CR1_AV_TYPE_BIT];
	assign avail_active_high_o    = cr1_reg[`CR1_AV_POL_BIT];
	assign strobe_rw_style_o      = cr1_reg[`CR1_RW_BIT];
	assign output_number_format_o = cr1_reg[`CR1_FMT_BIT];
	assign offset_enable_o        = cr1_reg[`CR1_OFFSET_BIT];
	assign register_readback_o    = cr1_reg[`CR1_REGISTER_READBACK_BIT];
	assign queue_clear_o          = qclr_reg;
	assign soft_reset_o           = srst_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_soft_reset_restore: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		soft_rst |=> (cr0_reg == `CR0_RESET_VALUE) && (cr1_reg == `CR1_RESET_VALUE))
		else $error("soft reset did not restore registers");
	a_default_diff_pair: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		soft_rst && !conv_done_i |=> ##1 convert_src_o == SRC_DIFF_A)
		else $error("default selection is not pair A");
	a_single_ended_pick: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cr0_reg[`CR0_SEL_HI:`CR0_DIFF_LO] == 3'h0) && (test_mode == TEST_NORMAL)
		|=> convert_src_o == src_t'({2'h0, $past(cr0_reg[`CR0_CHAN_HI:`CR0_CHAN_LO])}))
		else $error("single-ended pick wrong");
	a_diff_pair_pick: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cr0_reg[`CR0_SEL_HI:`CR0_SEL_LO] == 5'h05) && (test_mode == TEST_NORMAL)
		|=> convert_src_o == SRC_DIFF_B)
		else $error("differential pair B not selected");
	a_test_ref_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(test_mode == TEST_REF_LO) |=> convert_src_o == SRC_REF_LO)
		else $error("lower reference not selected in test");
	a_overflow_read_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_pulse && !queue_overflow_i
		|=> !overflow_flag_reg && (read_data_o[`CR1_OVERFLOW_FLAG_BIT] == $past(overflow_flag_reg)))
		else $error("overflow flag not cleared by read");
	a_scan_restart_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_cr0 |=> ##1 seq_index_o == 2'h0)
		else $error("scan did not restart after reconfiguration");
	a_cfg0_write_lands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_cr0 |=> cr0_reg == $past(data_s[`CFG_WIDTH-1:0]))
		else $error("input register write lost");
	// Queue register behaviour
	a_overflow_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		queue_overflow_i |=> overflow_flag_reg)
		else $error("overflow event lost");
	a_queue_clear_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_cr1 && !soft_rst |=> queue_clear_o == $past(data_s[`CR1_OVERFLOW_FLAG_BIT]))
		else $error("queue clear pulse wrong");
	a_cfg1_fields_stored: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_cr1 && !soft_rst |=> cr1_reg == {$past(data_s[`CFG_WIDTH-1:`CR1_TRIG_LO]), 2'h0})
		else $error("queue register fields not stored");
	a_read_returns_cfg1: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_pulse |=> read_data_o[`CFG_WIDTH-1:`CR1_TRIG_LO]
		== $past(cr1_reg[`CFG_WIDTH-1:`CR1_TRIG_LO]))
		else $error("read word does not match queue register");
	a_soft_beats_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		soft_rst |=> soft_reset_o && !queue_clear_o)
		else $error("soft reset pulse wrong");
	a_soft_clears_overflow_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		soft_rst && !queue_overflow_i |=> !overflow_flag_reg)
		else $error("soft reset left overflow set");
	// Test override
	a_test_hi_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(test_mode == TEST_REF_HI) |=> convert_src_o == SRC_REF_HI)
		else $error("upper reference not selected in test");
	a_test_mid_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(test_mode == TEST_REF_MD) |=> convert_src_o == SRC_REF_MID)
		else $error("mid reference not selected in test");
	// Main scenarios
	c_soft_reset: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) soft_rst);
	c_test_mid: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		convert_src_o == SRC_REF_MID);
	c_scan_pair_b: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		scan_active_o && (convert_src_o == SRC_DIFF_B));
	c_overflow_read: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_pulse && overflow_flag_reg);

endmodule
`default_nettype wire

/* File: adc_input_select_tb_top.sv */
// Purpose: Self-checking bench for the input selector and its registers
// Assumes: Host model paces every pin cycle
// Notes:   Expected values come from the selection and test tables
`timescale 1ns/100ps
`default_nettype none
module adc_input_select_tb_top;
	import adc_sel_pkg::*;
	logic        core_clk_i, rst_n_i, conv_done_i, queue_overflow_i;
	logic [11:0] bus_data_i;
	logic        bus_wr_n_i, bus_rd_n_i, read_data_oe_o, scan_active_o;
	logic [9:0]  read_data_o, rd;
	src_t        convert_src_o;
	logic [1:0]  seq_index_o, trigger_level_o;
	logic        vref_external_o, single_conv_mode_o, power_down_o;
	logic        avail_pulse_type_o, avail_active_high_o, strobe_rw_style_o;
	logic        output_number_format_o, offset_enable_o, register_readback_o;
	logic        queue_clear_o, soft_reset_o, oe;
	int          n_errors, n_checks, n_qc, n_sr, n_cyc;
	wire logic [7:0] cfg1_img;
	assign cfg1_img = {register_readback_o, offset_enable_o, output_number_format_o,
		strobe_rw_style_o, avail_active_high_o, avail_pulse_type_o, trigger_level_o};

	adc_input_select adc_input_select_i (.core_clk_i, .rst_n_i, .bus_data_i, .bus_wr_n_i,
		.bus_rd_n_i, .conv_done_i, .queue_overflow_i, .read_data_o, .read_data_oe_o,
		.convert_src_o, .seq_index_o, .scan_active_o, .vref_external_o, .single_conv_mode_o,
		.power_down_o, .trigger_level_o, .avail_pulse_type_o, .avail_active_high_o,
		.strobe_rw_style_o, .output_number_format_o, .offset_enable_o,
		.register_readback_o, .queue_clear_o, .soft_reset_o);
	host_bus_model host_bus_model_i (.core_clk_i, .read_data_i(read_data_o),
		.read_oe_i(read_data_oe_o), .bus_data_o(bus_data_i), .bus_wr_n_o(bus_wr_n_i),
		.bus_rd_n_o(bus_rd_n_i));

	// ------------------------------------------------------------------
	// Clock, pulse counters and hang guard
	// ------------------------------------------------------------------
	initial core_clk_i = 1'b0;
	always #25 core_clk_i = ~core_clk_i;
	// One-cycle pulses are counted so a task can judge them afterwards
	always @(posedge core_clk_i) begin
		n_qc += (queue_clear_o === 1'b1);
		n_sr += (soft_reset_o === 1'b1);
		n_cyc++;
		if (n_cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		chk("src", 12'h004, 12'(convert_src_o));
		chk("scan", 12'h000, 12'(scan_active_o));
		chk("cfg1", 12'h00C, 12'(cfg1_img));
		host_bus_model_i.rd_reg(rd, oe);
		chk("read", 12'h030, 12'(rd));
		chk("oe", 12'h001, 12'(oe));
	endtask
	// Fixed inputs, pairs and all test values; last row returns to normal
	task automatic t_single();
		logic [11:0] tab [10] = '{12'h000, 12'h011, 12'h022, 12'h033, 12'h044, 12'h055,
			12'h156, 12'h257, 12'h358, 12'h055};
		foreach (tab[i]) begin
			host_bus_model_i.wr_reg(2'h0, {tab[i][9:8], 1'b0, tab[i][7:4], 3'h0});
			chk("src", 12'(tab[i][3:0]), 12'(convert_src_o));
		end
	endtask
	// Six scan codes, each stepped past its wrap
	task automatic t_scan();
		logic [4:0]  code [6] = '{5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
		logic [15:0] seq  [6] = '{16'h0010, 16'h0210, 16'h3210, 16'h0050, 16'h0510, 16'h0054};
		int          len  [6] = '{2, 3, 4, 2, 3, 2};
		foreach (code[i]) begin
			host_bus_model_i.wr_reg(2'h0, {2'h0, code[i], 3'h0});
			chk("scan", 12'h001, 12'(scan_active_o));
			for (int k = 0; k < 6; k++) begin
				chk("src", 12'(seq[i][4*(k%len[i]) +: 4]), 12'(convert_src_o));
				chk("index", 12'(k % len[i]), 12'(seq_index_o));
				@(posedge core_clk_i);
				conv_done_i <= 1'b1;
				@(posedge core_clk_i);
				conv_done_i <= 1'b0;
				@(posedge core_clk_i);
				#1;
			end
		end
	endtask
	// Stored fields, clear pulse and overflow that clears on read
	task automatic t_cfg1();
		host_bus_model_i.wr_reg(2'h1, 10'h3CA);
		chk("cfg1", 12'h0F2, 12'(cfg1_img));
		chk("clear pulses", 12'h001, 12'(n_qc));
		@(posedge core_clk_i);
		queue_overflow_i <= 1'b1;
		@(posedge core_clk_i);
		queue_overflow_i <= 1'b0;
		host_bus_model_i.rd_reg(rd, oe);
		chk("read overflow_flag", 12'h3CA, 12'(rd));
		host_bus_model_i.rd_reg(rd, oe);
		chk("read clear", 12'h3C8, 12'(rd));
	endtask
	task automatic t_soft();
		host_bus_model_i.wr_reg(2'h0, 10'h39F);
		chk("test src", 12'h008, 12'(convert_src_o));
		chk("scan", 12'h001, 12'(scan_active_o));
		chk("cfg0 set", 12'h007, 12'({vref_external_o, single_conv_mode_o, power_down_o}));
		host_bus_model_i.wr_reg(2'h1, 10'h3FF);
		chk("resets", 12'h001, 12'(n_sr));
		chk("clear pulses", 12'h001, 12'(n_qc));
		chk("src", 12'h004, 12'(convert_src_o));
		chk("cfg0 low", 12'h000, 12'({vref_external_o, single_conv_mode_o, power_down_o}));
		host_bus_model_i.rd_reg(rd, oe);
		chk("read", 12'h030, 12'(rd));
	endtask

	// Reset held for five cycles, then every scenario in turn
	initial begin
		rst_n_i = 1'b0;
		conv_done_i = 1'b0;
		queue_overflow_i = 1'b0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		t_reset();
		t_single();
		t_scan();
		t_cfg1();
		t_soft();
		end_sim();
	end
endmodule
`default_nettype wire

/* File: adc_sel_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the input selector
// Assumes: Included by bare name from the design modules
// Notes:   Definitions only; no logic lives here
`ifndef ADC_SEL_MAP_SVH
`define ADC_SEL_MAP_SVH

// ----------------------------------------------------------------------
// Register addressing on the high data lines
// ----------------------------------------------------------------------
`define CFG_ADDR_LO      10
`define CFG_ADDR_HI      11
`define CFG_ADDR_CR0     2'h0
`define CFG_ADDR_CR1     2'h1
`define CFG_WIDTH        10
`define BUS_WIDTH        12

// ----------------------------------------------------------------------
// Input and test configuration fields
// ----------------------------------------------------------------------
`define CR0_VREF_BIT     0
`define CR0_MODE_BIT     1
`define CR0_PD_BIT       2
`define CR0_SEL_LO       3
`define CR0_SEL_HI       7
`define CR0_CHAN_LO      3
`define CR0_CHAN_HI      4
`define CR0_DIFF_LO      5
`define CR0_DIFF_HI      6
`define CR0_SCAN_BIT     7
`define CR0_TEST_LO      8
`define CR0_TEST_HI      9
`define CR0_RESET_VALUE  10'h020

// ----------------------------------------------------------------------
// Queue and interface configuration fields
// ----------------------------------------------------------------------
`define CR1_SOFT_RST_BIT 0
`define CR1_OVERFLOW_FLAG_BIT     1
`define CR1_TRIG_LO      2
`define CR1_TRIG_HI      3
`define CR1_AV_TYPE_BIT  4
`define CR1_AV_POL_BIT   5
`define CR1_RW_BIT       6
`define CR1_FMT_BIT      7
`define CR1_OFFSET_BIT   8
`define CR1_REGISTER_READBACK_BIT    9
`define CR1_RESET_VALUE  10'h030

// ----------------------------------------------------------------------
// Pin synchroniser depth
// ----------------------------------------------------------------------
`define SYNC_STAGES      2

`endif

/* File: adc_sel_pkg.sv */
// Purpose: Types shared by the input selector modules
// Assumes: adc_sel_map.svh holds the numbers
// Notes:   Source codes are what the analog front end is told to convert
package adc_sel_pkg;

	// ------------------------------------------------------------------
	// Conversion source
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		SRC_A_POS   = 4'h0,
		SRC_A_NEG   = 4'h1,
		SRC_B_POS   = 4'h2,
		SRC_B_NEG   = 4'h3,
		SRC_DIFF_A  = 4'h4,
		SRC_DIFF_B  = 4'h5,
		SRC_REF_HI  = 4'h6,
		SRC_REF_MID = 4'h7,
		SRC_REF_LO  = 4'h8,
		SRC_NONE    = 4'hF
	} src_t;

	// ------------------------------------------------------------------
	// Test field values
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		TEST_NORMAL = 2'h0,
		TEST_REF_HI = 2'h1,
		TEST_REF_MD = 2'h2,
		TEST_REF_LO = 2'h3
	} test_t;

endpackage

/* File: host_bus_model.sv */
// Purpose: Host processor model driving the parallel configuration pins
// Assumes: Strobes are paced for the two-flop pin synchronisers
// Notes:   Data lines turn over once the hold time has run out
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
	input  wire logic        core_clk_i,
	input  wire logic [9:0]  read_data_i,
	input  wire logic        read_oe_i,
	output logic      [11:0] bus_data_o,
	output logic             bus_wr_n_o,
	output logic             bus_rd_n_o
);
	// ------------------------------------------------------------------
	// Pin cycles
	// ------------------------------------------------------------------
	// Strobes idle high from time zero
	initial begin
		bus_data_o = 12'h000;
		bus_wr_n_o = 1'b1;
		bus_rd_n_o = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// only listed codes; data held 3 cycles around a 4 cycle strobe
	task automatic wr_reg(input logic [1:0] addr, input logic [9:0] val);
		@(posedge core_clk_i);
		bus_data_o <= {addr, val};
		wait_clk(3);
		bus_wr_n_o <= 1'b0;
		wait_clk(4);
		bus_wr_n_o <= 1'b1;
		wait_clk(3);
		// Stale data would hide a late sample, so it is inverted
		bus_data_o <= ~{addr, val};
		wait_clk(2);
	endtask
	// Read word is taken well after the registered answer lands
	task automatic rd_reg(output logic [9:0] val, output logic oe);
		@(posedge core_clk_i);
		bus_rd_n_o <= 1'b0;
		wait_clk(5);
		val = read_data_i;
		oe = read_oe_i;
		bus_rd_n_o <= 1'b1;
		wait_clk(4);
	endtask
endmodule
`default_nettype wire

/* File: pin_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Pins are quasi-static around strobes
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
`include "adc_sel_map.svh"

module pin_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	// ------------------------------------------------------------------
	// Per-bit stages
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic [`SYNC_STAGES-1:0] stage_reg;
			logic [`SYNC_STAGES-1:0] stage_next;
			// Shift in the pin
			always_comb begin
				stage_next = {stage_reg[`SYNC_STAGES-2:0], async_i[gi]};
			end
			// Stages reset to the pin's idle level, so release makes no false edge
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stage_reg <= {`SYNC_STAGES{RESET_LEVEL[gi]}};
				end else begin
					stage_reg <= stage_next;
				end
			end
			assign sync_o[gi] = stage_reg[`SYNC_STAGES-1];
		end
	endgenerate

endmodule
`default_nettype wire

/* File: scan_sequencer.sv */
// Purpose: Decodes the five selection bits and steps through autoscan entries
// Assumes: step_i pulses once per finished conversion, restart_i on reconfiguration
// Notes:   Reserved codes give SRC_NONE; the host never writes them
`timescale 1ns/100ps
`default_nettype none
`include "adc_sel_map.svh"

module scan_sequencer (
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [4:0]        sel_code_i,
	input  wire logic              restart_i,
	input  wire logic              step_i,
	output adc_sel_pkg::src_t      src_o,
	output logic      [1:0]        index_o,
	output logic                   scan_o
);
	import adc_sel_pkg::*;

	logic [1:0] index_reg;
	logic [1:0] index_next;
	logic [1:0] last_index;

	// ------------------------------------------------------------------
	// Sequence tables
	// ------------------------------------------------------------------
	function automatic logic [1:0] last_of(input logic [4:0] code);
		case (code)
			5'h11:   last_of = 2'h1;
			5'h12:   last_of = 2'h2;
			5'h13:   last_of = 2'h3;
			5'h15:   last_of = 2'h1;
			5'h16:   last_of = 2'h2;
			5'h19:   last_of = 2'h1;
			default: last_of = 2'h0;
		endcase
	endfunction

	function automatic src_t entry_of(input logic [4:0] code, input logic [1:0] idx);
		case (code)
			5'h00, 5'h01, 5'h02, 5'h03: entry_of = src_t'({2'h0, code[1:0]});
			5'h04:   entry_of = SRC_DIFF_A;
			5'h05:   entry_of = SRC_DIFF_B;
			5'h11:   entry_of = src_t'({3'h0, idx[0]});
			5'h12, 5'h13: entry_of = src_t'({2'h0, idx});
			5'h15:   entry_of = idx[0] ? SRC_DIFF_B : SRC_A_POS;
			5'h16:   entry_of = (idx == 2'h2) ? SRC_DIFF_B : src_t'({3'h0, idx[0]});
			5'h19:   entry_of = idx[0] ? SRC_DIFF_B : SRC_DIFF_A;
			default: entry_of = SRC_NONE;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Entry index
	// ------------------------------------------------------------------
	// advance and wrap
	always_comb begin
		last_index = last_of(sel_code_i);
		if (restart_i) begin
			index_next = 2'h0;
		end else if (step_i && (index_reg >= last_index)) begin
			index_next = 2'h0;
		end else if (step_i) begin
			index_next = index_reg + 2'h1;
		end else begin
			index_next = index_reg;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_reg <= 2'h0;
		end else begin
			index_reg <= index_next;
		end
	end

	assign src_o   = entry_of(sel_code_i, index_reg);
	assign index_o = index_reg;
	assign scan_o  = sel_code_i[4];

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_scan_wraps_first: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		step_i && !restart_i && (index_reg == last_index) |=> index_reg == 2'h0)
		else $error("autoscan did not wrap to first entry");
	a_scan_steps_next: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		step_i && !restart_i && (index_reg < last_index) && $stable(sel_code_i)
		|=> index_reg == $past(index_reg) + 2'h1)
		else $error("autoscan did not step to next entry");
	a_two_pairs_alt: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(sel_code_i == 5'h19) |-> (src_o == (index_reg[0] ? SRC_DIFF_B : SRC_DIFF_A)))
		else $error("pair alternation wrong");
	a_four_inputs_seq: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(sel_code_i == 5'h13) && (index_reg == 2'h3) |-> src_o == SRC_B_NEG)
		else $error("fourth scan entry wrong");
	c_four_wrap: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(sel_code_i == 5'h13) && step_i && (index_reg == 2'h3));

endmodule
`default_nettype wire
